// *** pkg/color_adjust_pkg.sv ***
/*
  Shared constants and carriers for the color adjust stage.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package color_adjust_pkg;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [7:0] IDX_RED_GAIN = 8'h00_AE;
  localparam logic [7:0] IDX_RED_OFFSET = 8'h00_AF;
  localparam logic [7:0] IDX_GREEN_GAIN = 8'h00_B0;
  localparam logic [7:0] IDX_GREEN_OFFSET = 8'h00_B1;
  localparam logic [7:0] IDX_RED_CURVE_PORT = 8'h00_B2;
  localparam logic [7:0] IDX_GREEN_CURVE_PORT = 8'h00_B3;
  localparam logic [7:0] IDX_BLUE_CURVE_PORT = 8'h00_B4;
  localparam logic [7:0] IDX_PALETTE_DATA_PORT = 8'h00_B5;
  localparam logic [7:0] IDX_PALETTE_BLEND_CTRL = 8'h00_B6;
  localparam logic [7:0] IDX_BLUE_GAIN = 8'h00_B7;
  localparam logic [7:0] IDX_BLUE_OFFSET = 8'h00_B8;
  localparam logic [7:0] IDX_CURVE_START_ADDR = 8'h00_B9;
  localparam logic [7:0] IDX_OVERLAY_CTRL = 8'h00_BA;
  localparam logic [7:0] IDX_STATUS = 8'h00_BB;

  // ****************************************
  // Field positions and arithmetic constants
  // ****************************************
  localparam int FORMAT_BIT = 3;
  localparam int BLEND_ENABLE_BIT = 7;
  localparam logic [8:0] GAIN_BIAS = 9'h0_080;
  localparam int GAIN_SHIFT = 7;
  localparam logic [3:0] BLEND_FULL = 4'h8;
  localparam logic [7:0] REG_RESET = 8'h00_00;

  // Pixel carrier
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic overlay;
  } pixel_t;

  // Output pixel carrier (gamma outputs are 10 bits)
  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } panel_t;

endpackage

// *** rtl/color_adjust.sv ***
/*
  Color adjust stage: gain, offset, gamma tables, palette and blend,
  with a small input FIFO and an AHB-Lite register slave.
  Assumes one pixel clock, single word AHB transfers, synchronous inputs.
*/
//
// Behaviour
// - Each channel is scaled by ((gain + 128) mod 256) / 128 using its own gain register.
// - Each channel adds its offset register read as a signed value from -128 to 127.
// - Each channel has its own 256-entry, 10-bit gamma table.
// - A gamma entry is written as low byte then high byte at its own channel's port address.
// - The gamma write address advances after every completed entry.
// - The 16-entry 16-bit palette is written low byte then high byte, indices 0 up to 15.
// - By default a palette entry splits as red 5, green 6, blue 5 bits from the top.
// - The format bit selects 5-6-5 or 5-5-5 entries, the latter with green's low bit from the overlay intensity.
// - With blending on and an overlay active the output is video*a/8 + palette*(1 - a/8).
// - A blend factor of zero drives the output straight from the palette.
// - A writable register sets the gamma starting address.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Generic FIFO
// ****************************************
module stream_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;
  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_t state, next_state;
  logic push, pop;

  // Handshake terms
  assign in_ready = (state.count != (AW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data = mem[state.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer update
  always_comb begin
    next_state = state;
    if (push) next_state.wr = AW'(state.wr + 1'b1);
    if (pop) next_state.rd = AW'(state.rd + 1'b1);
    next_state.count = (AW+1)'(state.count + push - pop);
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) state <= '0;
    else state <= next_state;
  end

  // Storage
  always_ff @(posedge clock) begin
    if (push) mem[state.wr] <= in_data;
  end
endmodule

// ****************************************
// Top: color adjust
// ****************************************
module color_adjust
  import color_adjust_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Video in
  input wire pixel_t pix_in,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  // Panel out
  output panel_t pix_out,
  output logic pix_out_valid
);
  typedef struct packed {
    logic [7:0] gain_r, gain_g, gain_b;
    logic [7:0] ofs_r, ofs_g, ofs_b;
    logic [7:0] blend;
    logic [7:0] start;
    logic [1:0] ovl_ctrl;
    logic [7:0] waddr_r, waddr_g, waddr_b;
    logic [2:0] low_pend;
    logic [7:0] low_r, low_g, low_b, low_p;
    logic pal_hi;
    logic [3:0] pal_idx;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] rd_data;
    logic s1_valid;
    logic [7:0] s1_r, s1_g, s1_b;
    logic s1_ovl;
    logic s2_valid;
    logic s2_ovl;
    logic [3:0] s2_idx;
    panel_t s2_gam;
    panel_t out;
    logic out_valid;
  } top_state_t;

  top_state_t st, next_st;
  logic rst_meta, rst_sync;
  logic [9:0] gamma_r [256];
  logic [9:0] gamma_g [256];
  logic [9:0] gamma_b [256];
  logic [15:0] palette_table [16];
  logic [24:0] fifo_data;
  logic fifo_valid;
  logic [9:0] rd_r, rd_g, rd_b;
  pixel_t fp;
  logic [7:0] adj [3];
  logic [7:0] in_ch [3];
  logic [7:0] gain_ch [3];
  logic [7:0] ofs_ch [3];
  logic [9:0] pal_ch [3];
  logic [9:0] gam_ch [3];
  logic [9:0] mix_ch [3];
  logic gam_wr [3];
  logic [7:0] gam_idx [3];
  logic [15:0] pal_entry;
  logic dp_wr;
  logic [3:0] a;

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Input FIFO, never stalled by the pipeline (stage always advances), held while overlay control bit 1 is set
  stream_fifo #(.WIDTH(25), .DEPTH(4)) u_fifo (
    .clock(clock),
    .rst_n(rst_sync),
    .in_data(pix_in),
    .in_valid(pix_in_valid),
    .in_ready(pix_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(st.ovl_ctrl[1] == 1'b0)
  );
  assign fp = pixel_t'(fifo_data);

  // ****************************************
  // Gain, offset and clamp per channel
  // ****************************************
  assign in_ch[0] = fp.red;
  assign in_ch[1] = fp.green;
  assign in_ch[2] = fp.blue;
  assign gain_ch[0] = st.gain_r;
  assign gain_ch[1] = st.gain_g;
  assign gain_ch[2] = st.gain_b;
  assign ofs_ch[0] = st.ofs_r;
  assign ofs_ch[1] = st.ofs_g;
  assign ofs_ch[2] = st.ofs_b;

  // Blend factor and palette entry for the overlay index
  assign a = {1'b0, st.blend[2:0]};
  // Index travels with its pixel so the palette meets the gamma result of the same pixel
  assign pal_entry = palette_table[st.s2_idx];
  // Palette split: 5-6-5 or 5-5-5 with overlay intensity as green LSB
  assign pal_ch[0] = {pal_entry[15:11], pal_entry[15:11]};
  assign pal_ch[1] = st.blend[FORMAT_BIT] ?
    {pal_entry[10:6], st.s2_ovl, pal_entry[10:7]} :
    {pal_entry[10:5], pal_entry[10:7]};
  assign pal_ch[2] = {pal_entry[4:0], pal_entry[4:0]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      logic [8:0] g9;
      logic [16:0] prod;
      logic signed [10:0] sum;
      logic [13:0] blend_sum;
      assign g9 = {1'b0, 8'(gain_ch[gi] + GAIN_BIAS[7:0])};
      assign prod = 17'(in_ch[gi] * g9) >> GAIN_SHIFT;
      assign sum = $signed({1'b0, prod[9:0]}) + 11'($signed(ofs_ch[gi]));
      assign adj[gi] = (sum < 0) ? 8'h00_00 :
        (sum > 11'sd255) ? 8'h00_FF : sum[7:0];
      assign blend_sum = 14'(gam_ch[gi] * a) + 14'(pal_ch[gi] * (BLEND_FULL - a));
      assign mix_ch[gi] = (a == 4'h0) ? pal_ch[gi] : blend_sum[12:3];
    end
  endgenerate

  // ****************************************
  // Gamma table read and write
  // ****************************************
  assign gam_wr[0] = st.wr_pend & (st.wr_idx == IDX_RED_CURVE_PORT);
  assign gam_wr[1] = st.wr_pend & (st.wr_idx == IDX_GREEN_CURVE_PORT);
  assign gam_wr[2] = st.wr_pend & (st.wr_idx == IDX_BLUE_CURVE_PORT);
  assign gam_idx[0] = st.waddr_r;
  assign gam_idx[1] = st.waddr_g;
  assign gam_idx[2] = st.waddr_b;
  assign gam_ch[0] = st.s2_gam.red;
  assign gam_ch[1] = st.s2_gam.green;
  assign gam_ch[2] = st.s2_gam.blue;

  // Table storage, written on the high byte of each pair
  always_ff @(posedge clock) begin
    if (gam_wr[0] && st.low_pend[0]) gamma_r[gam_idx[0]] <= {hwdata[1:0], st.low_r};
    if (gam_wr[1] && st.low_pend[1]) gamma_g[gam_idx[1]] <= {hwdata[1:0], st.low_g};
    if (gam_wr[2] && st.low_pend[2]) gamma_b[gam_idx[2]] <= {hwdata[1:0], st.low_b};
    if (st.wr_pend && st.wr_idx == IDX_PALETTE_DATA_PORT && st.pal_hi)
      palette_table[st.pal_idx] <= {hwdata[7:0], st.low_p};
    rd_r <= gamma_r[adj[0]];
    rd_g <= gamma_g[adj[1]];
    rd_b <= gamma_b[adj[2]];
  end

  assign dp_wr = st.wr_pend;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    // Address phase capture
    next_st.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_st.wr_pend = hwrite;
      next_st.wr_idx = haddr[9:2];
      case (haddr[9:2])
        IDX_RED_GAIN: next_st.rd_data = st.gain_r;
        IDX_RED_OFFSET: next_st.rd_data = st.ofs_r;
        IDX_GREEN_GAIN: next_st.rd_data = st.gain_g;
        IDX_GREEN_OFFSET: next_st.rd_data = st.ofs_g;
        IDX_BLUE_GAIN: next_st.rd_data = st.gain_b;
        IDX_BLUE_OFFSET: next_st.rd_data = st.ofs_b;
        IDX_PALETTE_BLEND_CTRL: next_st.rd_data = st.blend;
        IDX_CURVE_START_ADDR: next_st.rd_data = st.start;
        IDX_OVERLAY_CTRL: next_st.rd_data = {6'h00, st.ovl_ctrl};
        IDX_STATUS: next_st.rd_data = {st.pal_idx, 1'b0, st.low_pend};
        default: next_st.rd_data = 8'h00_00;
      endcase
    end
    // Data phase write
    if (dp_wr) begin
      case (st.wr_idx)
        IDX_RED_GAIN: next_st.gain_r = hwdata[7:0];
        IDX_RED_OFFSET: next_st.ofs_r = hwdata[7:0];
        IDX_GREEN_GAIN: next_st.gain_g = hwdata[7:0];
        IDX_GREEN_OFFSET: next_st.ofs_g = hwdata[7:0];
        IDX_BLUE_GAIN: next_st.gain_b = hwdata[7:0];
        IDX_BLUE_OFFSET: next_st.ofs_b = hwdata[7:0];
        IDX_PALETTE_BLEND_CTRL: next_st.blend = hwdata[7:0];
        IDX_OVERLAY_CTRL: next_st.ovl_ctrl = hwdata[1:0];
        IDX_CURVE_START_ADDR: begin
          next_st.start = hwdata[7:0];
          next_st.waddr_r = hwdata[7:0];
          next_st.waddr_g = hwdata[7:0];
          next_st.waddr_b = hwdata[7:0];
          next_st.low_pend = 3'b000;
        end
        IDX_RED_CURVE_PORT: begin
          next_st.low_pend[0] = ~st.low_pend[0];
          if (!st.low_pend[0]) next_st.low_r = hwdata[7:0];
          else next_st.waddr_r = 8'(st.waddr_r + 1'b1);
        end
        IDX_GREEN_CURVE_PORT: begin
          next_st.low_pend[1] = ~st.low_pend[1];
          if (!st.low_pend[1]) next_st.low_g = hwdata[7:0];
          else next_st.waddr_g = 8'(st.waddr_g + 1'b1);
        end
        IDX_BLUE_CURVE_PORT: begin
          next_st.low_pend[2] = ~st.low_pend[2];
          if (!st.low_pend[2]) next_st.low_b = hwdata[7:0];
          else next_st.waddr_b = 8'(st.waddr_b + 1'b1);
        end
        IDX_PALETTE_DATA_PORT: begin
          next_st.pal_hi = ~st.pal_hi;
          if (!st.pal_hi) next_st.low_p = hwdata[7:0];
          else next_st.pal_idx = 4'(st.pal_idx + 1'b1);
        end
        default: next_st.ovl_ctrl = st.ovl_ctrl;
      endcase
    end
    // Pixel pipeline: adjust, gamma, blend
    next_st.s1_valid = fifo_valid & ~st.ovl_ctrl[1];
    next_st.s1_ovl = fp.overlay;
    next_st.s1_r = adj[0];
    next_st.s1_g = adj[1];
    next_st.s1_b = fp.blue;
    next_st.s2_valid = st.s1_valid;
    next_st.s2_ovl = st.s1_ovl;
    next_st.s2_idx = st.s1_b[3:0];
    next_st.s2_gam = '{red: rd_r, green: rd_g, blue: rd_b};
    next_st.out_valid = st.s2_valid;
    if (st.blend[BLEND_ENABLE_BIT] && (st.s2_ovl || st.ovl_ctrl[0]))
      next_st.out = '{red: mix_ch[0], green: mix_ch[1], blue: mix_ch[2]};
    else
      next_st.out = st.s2_gam;
  end

  // State register
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) st <= '0;
    else st <= next_st;
  end

  // Read data and pixel outputs from flip-flops, ready and response tied to constants
  assign hrdata = {24'h00_0000, st.rd_data};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pix_out = st.out;
  assign pix_out_valid = st.out_valid;

  // ****************************************
  // Checks
  // ****************************************
  AST_ADDR_STEP: assert property (@(posedge clock) disable iff (!rst_sync)
    (dp_wr && st.wr_idx == IDX_RED_CURVE_PORT && st.low_pend[0] && !gam_wr[1])
    |=> st.waddr_r == 8'($past(st.waddr_r) + 1'b1))
    else $error("red gamma address did not advance");
  AST_LOW_HOLD: assert property (@(posedge clock) disable iff (!rst_sync)
    (dp_wr && st.wr_idx == IDX_GREEN_CURVE_PORT && !st.low_pend[1])
    |=> st.low_pend[1] && st.waddr_g == $past(st.waddr_g))
    else $error("low byte moved the green address");
  AST_START: assert property (@(posedge clock) disable iff (!rst_sync)
    (dp_wr && st.wr_idx == IDX_CURVE_START_ADDR)
    |=> st.waddr_b == $past(hwdata[7:0]) && st.start == $past(hwdata[7:0]))
    else $error("start address not loaded");
  AST_PAL_STEP: assert property (@(posedge clock) disable iff (!rst_sync)
    (dp_wr && st.wr_idx == IDX_PALETTE_DATA_PORT && st.pal_hi)
    |=> st.pal_idx == 4'($past(st.pal_idx) + 1'b1) && !st.pal_hi)
    else $error("palette index did not advance");
  AST_CLAMP_HI: assert property (@(posedge clock) disable iff (!rst_sync)
    (fp.red >= 8'h00_AB && st.gain_r == 8'h00_40 && !st.ofs_r[7]) |-> adj[0] == 8'h00_FF)
    else $error("clamp high failed");
  AST_CLAMP_LO: assert property (@(posedge clock) disable iff (!rst_sync)
    (fp.green == 8'h00_00 && st.ofs_g[7]) |-> adj[1] == 8'h00_00)
    else $error("clamp low failed");
  AST_UNITY: assert property (@(posedge clock) disable iff (!rst_sync)
    (st.gain_b == 8'h00_00 && st.ofs_b == 8'h00_00 && fp.blue[7:4] == 4'h0)
    |-> g_ch[2].prod[7:0] == fp.blue)
    else $error("unity gain changed value");
  AST_DIRECT: assert property (@(posedge clock) disable iff (!rst_sync)
    (st.blend[BLEND_ENABLE_BIT] && st.blend[2:0] == 3'b000 && st.s2_ovl
     && !(dp_wr && st.wr_idx == IDX_PALETTE_BLEND_CTRL))
    |=> pix_out.red == $past(pal_ch[0]))
    else $error("zero factor not direct from palette");
  AST_PIPE: assert property (@(posedge clock) disable iff (!rst_sync)
    st.s1_valid |-> ##2 pix_out_valid)
    else $error("pixel lost in pipeline");
  AST_FMT: assert property (@(posedge clock) disable iff (!rst_sync)
    st.blend[FORMAT_BIT] |-> pal_ch[1][4] == st.s2_ovl)
    else $error("555 green low bit wrong");
endmodule
`default_nettype wire

// *** tb/pixel_source.sv ***
/*
  Upstream pixel source model feeding the color adjust stage.
  Assumes its caller runs in step with the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module pixel_source
  import color_adjust_pkg::*;
(
  // Clock
  input wire logic clock,
  // Pixel handshake
  output var pixel_t pix_in,
  output var logic pix_in_valid,
  input wire logic pix_in_ready
);
  // ****************************************
  // Transfer
  // ****************************************
  // Idle lines at time zero
  initial begin
    pix_in = '0;
    pix_in_valid = 1'b0;
  end

  // Offer one pixel until taken, then show its inverse so stale data is never reused
  task automatic send(input pixel_t p);
    @(posedge clock);
    pix_in <= p;
    pix_in_valid <= 1'b1;
    do @(posedge clock); while (pix_in_ready !== 1'b1);
    pix_in_valid <= 1'b0;
    pix_in <= ~p;
  endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the color adjust stage.
  Assumes the package constants and a zero-wait AHB-Lite slave.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench
  import color_adjust_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] off;
    logic [7:0] vin;
    logic [7:0] adj;
  } row_t;
  logic clock, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pix_in_valid, pix_in_ready, pix_out_valid;
  pixel_t pix_in;
  panel_t pix_out;
  panel_t got[$];
  int failures, n_tests;
  logic [7:0] gidx [3] = '{IDX_RED_GAIN, IDX_GREEN_GAIN, IDX_BLUE_GAIN};
  logic [7:0] oidx [3] = '{IDX_RED_OFFSET, IDX_GREEN_OFFSET, IDX_BLUE_OFFSET};
  logic [7:0] cidx [3] = '{IDX_RED_CURVE_PORT, IDX_GREEN_CURVE_PORT, IDX_BLUE_CURVE_PORT};
  logic [7:0] ridx [10] = '{IDX_RED_GAIN, IDX_GREEN_GAIN, IDX_BLUE_GAIN, IDX_RED_OFFSET,
    IDX_GREEN_OFFSET, IDX_BLUE_OFFSET, IDX_PALETTE_BLEND_CTRL, IDX_CURVE_START_ADDR,
    IDX_OVERLAY_CTRL, 8'h10};
  // Gain, offset, input level, clamped level
  row_t rows [9] = '{'{8'h00, 8'h00, 8'h40, 8'h40}, '{8'h80, 8'h00, 8'hC8, 8'h00},
    '{8'hC0, 8'h00, 8'h64, 8'h32}, '{8'h40, 8'h00, 8'h64, 8'h96},
    '{8'h40, 8'h00, 8'hC8, 8'hFF}, '{8'h00, 8'hFF, 8'h00, 8'h00},
    '{8'h00, 8'h80, 8'hC8, 8'h48}, '{8'h00, 8'h10, 8'h20, 8'h30},
    '{8'hC0, 8'h80, 8'hC8, 8'h00}};

  color_adjust i_dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_in(pix_in),
    .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .pix_out(pix_out),
    .pix_out_valid(pix_out_valid));
  pixel_source i_src (.clock(clock), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready));

  // ****************************************
  // Clock, capture and helpers
  // ****************************************
  // Free running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Collect every output pixel
  always @(posedge clock) begin
    if (pix_out_valid === 1'b1) got.push_back(pix_out);
  end

  function automatic logic [9:0] gv(input int c, input int i);
    return 10'(i * 3 + c * 97);
  endfunction
  function automatic logic [15:0] pe(input int m);
    return {5'(m), 6'(m * 5), 5'(m + 8)};
  endfunction
  function automatic panel_t gp(input logic [7:0] a);
    return '{gv(0, a), gv(1, a), gv(2, a)};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One single-word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h00_0000, idx, 2'h0};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, {24'h00_0000, d}, x);
  endtask

  // Send one pixel and compare the channels selected by the mask (red, green, blue)
  task automatic px(input pixel_t p, input panel_t e, input logic [2:0] m);
    got.delete();
    i_src.send(p);
    for (int k = 0; k < 20 && got.size() == 0; k++) @(posedge clock);
    if (got.size() == 0) got.push_back('x);
    if (m[2]) chk("red", e.red, got[0].red);
    if (m[1]) chk("green", e.green, got[0].green);
    if (m[0]) chk("blue", e.blue, got[0].blue);
  endtask

  // Cut a hang short
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    test_done();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [9:0] v;
    logic [15:0] w;
    panel_t e;
    failures = 0;
    n_tests = 0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    repeat (10) @(posedge clock);
    chk("hreadyout in reset", 1, hreadyout);
    chk("valid in reset", 0, pix_out_valid);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    // Reset values and an unmapped read
    foreach (ridx[k]) begin
      bus(ridx[k], 1'b0, '0, d);
      chk("reset value", 0, d);
    end
    wr(IDX_RED_GAIN, 8'h5A);
    bus(IDX_RED_GAIN, 1'b0, '0, d);
    chk("gain readback", 32'h0000_005A, d);
    chk("hresp", 0, hresp);
    // Fill all three curves, red first, low byte then high byte
    wr(IDX_CURVE_START_ADDR, 8'h00);
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 256; i++) begin
        v = gv(c, i);
        wr(cidx[c], v[7:0]);
        wr(cidx[c], {6'h00, v[9:8]});
      end
    end
    // Ordinary cases
    foreach (rows[r]) begin
      for (int c = 0; c < 3; c++) begin
        wr(gidx[c], rows[r].gain);
        wr(oidx[c], rows[r].off);
      end
      px('{rows[r].vin, rows[r].vin, rows[r].vin, 1'b0}, gp(rows[r].adj), 3'h7);
    end
    // Each channel uses its own gain and offset
    wr(IDX_RED_GAIN, 8'h80);
    wr(IDX_GREEN_GAIN, 8'h00);
    wr(IDX_BLUE_GAIN, 8'hC0);
    wr(IDX_RED_OFFSET, 8'h10);
    wr(IDX_GREEN_OFFSET, 8'h00);
    wr(IDX_BLUE_OFFSET, 8'hF0);
    px('{8'h64, 8'h64, 8'h64, 1'b0}, '{gv(0, 16), gv(1, 100), gv(2, 34)}, 3'h7);
    for (int c = 0; c < 3; c++) begin
      wr(gidx[c], 8'h00);
      wr(oidx[c], 8'h00);
    end
    // Restart the curves at 0x10 and rewrite two red entries
    wr(IDX_CURVE_START_ADDR, 8'h10);
    wr(IDX_RED_CURVE_PORT, 8'hAA);
    wr(IDX_RED_CURVE_PORT, 8'h03);
    wr(IDX_RED_CURVE_PORT, 8'h55);
    wr(IDX_RED_CURVE_PORT, 8'h01);
    px('{8'h10, 8'h10, 8'h10, 1'b0}, '{10'h3AA, gv(1, 16), gv(2, 16)}, 3'h7);
    px('{8'h11, 8'h11, 8'h11, 1'b0}, '{10'h155, gv(1, 17), gv(2, 17)}, 3'h7);
    // Palette fill and both entry formats with a zero factor
    for (int m = 0; m < 16; m++) begin
      w = pe(m);
      wr(IDX_PALETTE_DATA_PORT, w[7:0]);
      wr(IDX_PALETTE_DATA_PORT, w[15:8]);
    end
    bus(IDX_STATUS, 1'b0, '0, d);
    chk("status after fill", 0, d);
    for (int f = 0; f < 2; f++) begin
      wr(IDX_PALETTE_BLEND_CTRL, f ? 8'h88 : 8'h80);
      for (int m = 0; m < 16; m++) begin
        w = pe(m);
        e.red = {w[15:11], w[15:11]};
        e.green = f ? {w[10:6], 1'b1, w[10:7]} : {w[10:5], w[10:7]};
        e.blue = {w[4:0], w[4:0]};
        px('{8'h20, 8'h20, 8'(m), 1'b1}, e, 3'h7);
      end
    end
    // Blend factors 1 to 7 on red
    for (int a = 1; a < 8; a++) begin
      wr(IDX_PALETTE_BLEND_CTRL, 8'(8'h80 + a));
      e.red = 10'((gv(0, 8) * a + 264 * (8 - a)) / 8);
      px('{8'h08, 8'h08, 8'h08, 1'b1}, e, 3'h4);
    end
    // Blend off, no overlay, then forced background
    for (int k = 0; k < 3; k++) begin
      wr(IDX_PALETTE_BLEND_CTRL, k ? 8'h80 : 8'h00);
      wr(IDX_OVERLAY_CTRL, k == 2 ? 8'h01 : 8'h00);
      w = pe(5);
      e = k == 2 ? panel_t'({{w[15:11], w[15:11]}, {w[10:5], w[10:7]}, {w[4:0], w[4:0]}})
        : gp(8'h25);
      px('{8'h25, 8'h25, 8'h25, 1'(k == 0)}, e, 3'h7);
    end
    // Fill the buffer while stalled, then drain it in order
    wr(IDX_PALETTE_BLEND_CTRL, 8'h00);
    wr(IDX_OVERLAY_CTRL, 8'h02);
    got.delete();
    for (int k = 1; k < 5; k++) i_src.send('{8'(k), 8'(k), 8'(k), 1'b0});
    fork
      i_src.send('{8'h05, 8'h05, 8'h05, 1'b0});
    join_none
    repeat (8) @(posedge clock);
    chk("ready when full", 0, pix_in_ready);
    chk("outputs while stalled", 0, got.size());
    wr(IDX_OVERLAY_CTRL, 8'h00);
    for (int k = 0; k < 60 && got.size() < 5; k++) @(posedge clock);
    while (got.size() < 5) got.push_back('x);
    for (int k = 0; k < 5; k++) chk("drain order", gv(0, k + 1), got[k].red);
    test_done();
  end
endmodule

`default_nettype wire
